// file: rtl/fwd_pkg.sv
// Package with register map, unlock keys and timing constants of the watchdog
package fwd_pkg;
	localparam logic [3:0] FWD_CTRL_OFS = 4'h0;
	localparam logic [3:0] FWD_MODE_OFS = 4'h4;
	localparam logic [3:0] FWD_STAT_OFS = 4'h8;
	localparam logic [1:0] FWD_MODE_RESET = 2'h2;
	localparam logic [7:0] FWD_UNLOCK_FIRST = 8'h5A;
	localparam logic [7:0] FWD_UNLOCK_SECOND = 8'hA5;
	localparam int FWD_DIV = 128;
	localparam int FWD_CNT_W = 18;
	localparam logic [FWD_CNT_W-1:0] FWD_PER_0 = 18'h01000;
	localparam logic [FWD_CNT_W-1:0] FWD_PER_1 = 18'h04000;
	localparam logic [FWD_CNT_W-1:0] FWD_PER_2 = 18'h10000;
	localparam logic [FWD_CNT_W-1:0] FWD_PER_3 = 18'h3FFFF;
	localparam logic [1:0] FWD_RESP_OKAY = 2'h0;
	localparam logic [1:0] FWD_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {FWD_RUN, FWD_INIT, FWD_ARMED, FWD_RESET} fwd_state_e;
endpackage

// file: rtl/fwd_watchdog.sv
// Free-running watchdog with unlock-pair restart and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module fwd_watchdog
	import fwd_pkg::*;
#(
	// Slow rising edges to the first counter tick; the seven-bit divider wraps, so later ticks come every 128, at most 128
	parameter int DIV_RATIO = FWD_DIV
)
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic low_speed_clock_in,
	input wire logic stop_mode_in,
	input wire logic halt_mode_in,
	input wire logic build_enable_option_in,
	input wire logic halt_stop_option_a_in,
	input wire logic halt_stop_option_b_in,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic first_overflow_irq_out,
	output logic halt_wake_out,
	output logic watchdog_reset_out
);
	typedef struct packed {
		logic [2:0] lsc_sync;
		logic lsc_level;
		logic [6:0] div_cnt;
		logic [FWD_CNT_W-1:0] count;
		logic unlock_sequence_pointer;
		// Set only by the correct first half at pointer 0
		logic first_ok;
		logic [1:0] overflow_period_select;
		fwd_state_e state;
		logic halt_prev;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
		logic wake;
		logic wdt_rst;
	} fwd_state_s;

	fwd_state_s st_reg;
	fwd_state_s st_next;

	// Period field to terminal count
	function automatic logic [FWD_CNT_W-1:0] fwd_limit(input logic [1:0] sel);
		logic [FWD_CNT_W-1:0] lim;
		lim = FWD_PER_3;
		case (sel)
			2'h0: lim = FWD_PER_0 - 18'h00001;
			2'h1: lim = FWD_PER_1 - 18'h00001;
			2'h2: lim = FWD_PER_2 - 18'h00001;
			default: lim = FWD_PER_3;
		endcase
		return lim;
	endfunction

	// Counts in units of the divided tick, so limit is terminal count over 128
	function automatic logic [FWD_CNT_W-1:0] fwd_tick_limit(input logic [1:0] sel);
		logic [FWD_CNT_W-1:0] full;
		full = fwd_limit(sel);
		return {7'h00, full[FWD_CNT_W-1:7]};
	endfunction

	// Word decode shared by the write path's three targets
	function automatic logic fwd_hit(input logic [11:0] addr, input logic [3:0] ofs);
		return (addr[3:0] == ofs) && (addr[11:4] == 8'h00);
	endfunction

	logic lsc_rise;
	logic lsc_fall;
	logic divided_count_tick;
	logic stopped;
	logic halt_stop;
	logic wr_go;
	logic rd_go;
	logic ctrl_wr;
	logic [7:0] wbyte;
	logic [11:0] aw_eff;
	logic [31:0] w_eff;
	logic [3:0] s_eff;

	always_comb
	begin
		st_next = st_reg;
		// Third stage compared with second; first stage feeds only second
		st_next.lsc_sync = {st_reg.lsc_sync[1:0], low_speed_clock_in};
		lsc_rise = st_reg.lsc_sync[1] && st_reg.lsc_sync[2] && !st_reg.lsc_level;
		lsc_fall = !st_reg.lsc_sync[1] && !st_reg.lsc_sync[2] && st_reg.lsc_level;
		if (lsc_rise || lsc_fall)
		begin
			st_next.lsc_level = st_reg.lsc_sync[2];
		end
		halt_stop = !halt_stop_option_a_in && halt_stop_option_b_in && halt_mode_in;
		// No register bit can reach this; only pins and options stop it
		stopped = !build_enable_option_in || stop_mode_in || halt_stop;
		divided_count_tick = 1'b0;
		if (lsc_rise && !stopped)
		begin
			st_next.div_cnt = st_reg.div_cnt + 7'h01;
			divided_count_tick = (st_reg.div_cnt == 7'(DIV_RATIO - 1));
		end
		st_next.halt_prev = halt_stop;
		if (halt_stop && !st_reg.halt_prev)
		begin
			st_next.count = '0;
			st_next.div_cnt = 7'h00;
		end

		// AXI write side: address and data accepted in either order
		st_next.awready = 1'b0;
		st_next.wready = 1'b0;
		st_next.arready = 1'b0;
		if (s_axi_awvalid && st_reg.awready)
		begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready)
		begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		aw_eff = st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr;
		w_eff = st_reg.w_held ? st_reg.w_data : s_axi_wdata;
		s_eff = st_reg.w_held ? st_reg.w_strb : s_axi_wstrb;
		wr_go = (st_reg.aw_held || (s_axi_awvalid && st_reg.awready))
			&& (st_reg.w_held || (s_axi_wvalid && st_reg.wready)) && !st_reg.bvalid;
		if (!st_reg.aw_held && !st_reg.awready && s_axi_awvalid && !st_reg.bvalid)
		begin
			st_next.awready = 1'b1;
		end
		if (!st_reg.w_held && !st_reg.wready && s_axi_wvalid && !st_reg.bvalid)
		begin
			st_next.wready = 1'b1;
		end
		ctrl_wr = 1'b0;
		wbyte = w_eff[7:0];
		if (wr_go)
		begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.awready = 1'b0;
			st_next.wready = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = FWD_RESP_OKAY;
			if (fwd_hit(aw_eff, FWD_CTRL_OFS))
			begin
				ctrl_wr = s_eff[0];
			end
			else if (fwd_hit(aw_eff, FWD_MODE_OFS))
			begin
				if (s_eff[0])
				begin
					st_next.overflow_period_select = w_eff[1:0];
				end
			end
			else if (!fwd_hit(aw_eff, FWD_STAT_OFS))
			begin
				st_next.bresp = FWD_RESP_SLVERR;
			end
		end
		if (st_reg.bvalid && s_axi_bready)
		begin
			st_next.bvalid = 1'b0;
		end

		// Unlock sequence; writes dropped while init window holds
		if (ctrl_wr && st_reg.state != FWD_INIT)
		begin
			st_next.unlock_sequence_pointer = !st_reg.unlock_sequence_pointer;
			if (!st_reg.unlock_sequence_pointer)
			begin
				// Remember the first half; a stray value spoils the pair
				st_next.first_ok = (wbyte == FWD_UNLOCK_FIRST);
			end
			else
			begin
				st_next.first_ok = 1'b0;
				// Both halves needed in succession, else a lone second half would clear
				if (st_reg.first_ok && wbyte == FWD_UNLOCK_SECOND)
				begin
					st_next.count = '0;
					st_next.div_cnt = 7'h00;
					if (st_reg.state == FWD_ARMED)
					begin
						st_next.state = FWD_RUN;
					end
				end
			end
		end

		// Counter and overflow state machine
		st_next.wake = 1'b0;
		case (st_reg.state)
			FWD_RUN, FWD_ARMED:
			begin
				if (divided_count_tick)
				begin
					if (st_reg.count >= fwd_tick_limit(st_reg.overflow_period_select))
					begin
						st_next.count = '0;
						st_next.unlock_sequence_pointer = 1'b0;
						st_next.first_ok = 1'b0;
						if (st_reg.state == FWD_RUN)
						begin
							st_next.state = FWD_INIT;
							st_next.irq = 1'b1;
							st_next.wake = halt_mode_in;
						end
						else
						begin
							st_next.state = FWD_RESET;
							st_next.wdt_rst = 1'b1;
						end
					end
					else
					begin
						st_next.count = st_reg.count + 18'h00001;
					end
				end
			end
			FWD_INIT:
			begin
				st_next.irq = 1'b0;
				st_next.count = '0;
				st_next.unlock_sequence_pointer = 1'b0;
				st_next.first_ok = 1'b0;
				// Half slow period ends on the next slow falling edge
				if (lsc_fall)
				begin
					st_next.state = FWD_ARMED;
				end
			end
			FWD_RESET:
			begin
				st_next.wdt_rst = 1'b1;
			end
			default:
			begin
				st_next.state = FWD_RUN;
			end
		endcase

		// AXI read side
		rd_go = s_axi_arvalid && st_reg.arready;
		if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid)
		begin
			st_next.arready = 1'b1;
		end
		if (rd_go)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = FWD_RESP_OKAY;
			st_next.rdata = 32'h00000000;
			if (s_axi_araddr[11:4] != 8'h00)
			begin
				st_next.rresp = FWD_RESP_SLVERR;
			end
			else if (s_axi_araddr[3:0] == FWD_CTRL_OFS)
			begin
				st_next.rdata = {31'h00000000, st_reg.unlock_sequence_pointer};
			end
			else if (s_axi_araddr[3:0] == FWD_MODE_OFS)
			begin
				st_next.rdata = {30'h00000000, st_reg.overflow_period_select};
			end
			else if (s_axi_araddr[3:0] == FWD_STAT_OFS)
			begin
				st_next.rdata = {30'h00000000, st_reg.state == FWD_ARMED, stopped};
			end
			else
			begin
				st_next.rresp = FWD_RESP_SLVERR;
			end
		end
		if (st_reg.rvalid && s_axi_rready)
		begin
			st_next.rvalid = 1'b0;
		end
		// Disabled unit holds counter, divider, state and the irq, wake and reset outputs idle so a late enable starts clean
		if (!build_enable_option_in)
		begin
			st_next.irq = 1'b0;
			st_next.wake = 1'b0;
			st_next.wdt_rst = 1'b0;
			st_next.state = FWD_RUN;
			st_next.count = '0;
			st_next.div_cnt = 7'h00;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			st_reg <= '0;
			st_reg.state <= FWD_RUN;
			st_reg.overflow_period_select <= FWD_MODE_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign first_overflow_irq_out = st_reg.irq;
	assign halt_wake_out = st_reg.wake;
	assign watchdog_reset_out = st_reg.wdt_rst;
endmodule

// file: testbench/fwd_far_model.sv
// Slow oscillator and interrupt counter standing beside the watchdog
`timescale 1ns/1ps
module fwd_far_model (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic first_overflow_irq_in,
	output logic low_speed_clock_out,
	output int irq_count_out
);
	// Oscillator runs free, never gated by the bus side
	initial
	begin
		low_speed_clock_out = 1'b0;
		forever #200 low_speed_clock_out = ~low_speed_clock_out;
	end
	always @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			irq_count_out <= 0;
		else if (first_overflow_irq_in)
			irq_count_out <= irq_count_out + 1;
	end
endmodule

// file: testbench/fwd_watchdog_assertions.sv
// Port checker for the watchdog
`timescale 1ns/1ps
module fwd_watchdog_chk (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic build_enable_option_in,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic first_overflow_irq_out,
	input wire logic halt_wake_out,
	input wire logic watchdog_reset_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_irq_one_pulse: assert property (first_overflow_irq_out |=> !first_overflow_irq_out)
		else $error("irq wider than one cycle");
	a_reset_sticky: assert property (watchdog_reset_out |=> watchdog_reset_out)
		else $error("watchdog reset dropped");
	a_off_silent: assert property (!build_enable_option_in |->
		!first_overflow_irq_out && !watchdog_reset_out) else $error("disabled unit fired");
	a_wake_with_irq: assert property (halt_wake_out |-> first_overflow_irq_out)
		else $error("wake without irq");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
	a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
	a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind fwd_watchdog fwd_watchdog_chk i_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.build_enable_option_in(build_enable_option_in), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.first_overflow_irq_out(first_overflow_irq_out), .halt_wake_out(halt_wake_out),
	.watchdog_reset_out(watchdog_reset_out));

// file: testbench/tb.sv
// Self-checking bench for the watchdog
`timescale 1ns/1ps
module tb;
	import fwd_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'h1;
	logic awr, wr, bv, arr, rv, low_speed_clock, irq, wrst, wake;
	logic hlt = 1'b1, stp = 1'b0, opa = 1'b1, opb = 1'b0;
	int wake_n = 0;
	logic [1:0] bresp, rresp;
	logic [31:0] rd;
	logic ptr;
	int irq_n, n;
	int n_errors = 0;
	int samples_checked = 0;
	fwd_watchdog i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .low_speed_clock_in(low_speed_clock),
		.stop_mode_in(stp), .halt_mode_in(hlt), .build_enable_option_in(1'b1),
		.halt_stop_option_a_in(opa), .halt_stop_option_b_in(opb), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.first_overflow_irq_out(irq), .halt_wake_out(wake), .watchdog_reset_out(wrst));
	always @(posedge clk_in)
	begin
		if (wake === 1'b1)
			wake_n <= wake_n + 1;
	end
	fwd_far_model i_far (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.first_overflow_irq_in(irq), .low_speed_clock_out(low_speed_clock), .irq_count_out(irq_n));
	initial
	begin
		forever #50 clk_in = ~clk_in;
	end
	task automatic tally_and_finish;
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Hung bus or missing event ends the run at once
	task automatic give_up;
		n_errors++;
		$display("ERROR %0t wait ran out", $time);
		tally_and_finish;
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		n = 0;
		awa <= a;
		wd <= d;
		ws <= 4'h1 | 4'($urandom);
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end
		while (bv !== 1'b1 && n < 64);
		if (n >= 64) give_up;
		chk({bresp, 32'h0}, {er, 32'h0});
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		n = 0;
		ara <= a;
		arv <= 1'b1;
		rrd <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
			if (arr) arv <= 1'b0;
		end
		while (rv !== 1'b1 && n < 64);
		if (n >= 64) give_up;
		chk({rresp, rd}, {er, e});
	endtask
	task automatic wait_irq(input int k, input int lim);
		n = 0;
		while (irq_n < k && n < lim)
		begin
			@(posedge clk_in);
			n++;
		end
		if (irq_n < k) give_up;
	endtask
	initial
	begin
		void'($urandom(31));
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		rd_chk(12'h000, 32'h0, FWD_RESP_OKAY);
		rd_chk(12'h004, 32'h2, FWD_RESP_OKAY);
		wr_reg(12'h010, 32'h5A, FWD_RESP_SLVERR);
		wr_reg(12'h004, 32'h0, FWD_RESP_OKAY);
		rd_chk(12'h004, 32'h0, FWD_RESP_OKAY);
		ptr = 1'b0;
		repeat (4)
		begin
			wr_reg(12'h000, 32'($urandom) & 32'hFF, FWD_RESP_OKAY);
			ptr = ~ptr;
			rd_chk(12'h000, {31'h0, ptr}, FWD_RESP_OKAY);
		end
		// Clear values in swapped order, then a dangling first half
		repeat (8000) @(posedge clk_in);
		wr_reg(12'h000, 32'hA5, FWD_RESP_OKAY);
		wr_reg(12'h000, 32'h5A, FWD_RESP_OKAY);
		wr_reg(12'h000, 32'h5A, FWD_RESP_OKAY);
		wait_irq(1, 12000);
		hlt <= 1'b0;
		chk(34'(wake_n), 34'h1);
		chk({33'h0, wrst}, 34'h0);
		rd_chk(12'h000, 32'h0, FWD_RESP_OKAY);
		repeat (8000) @(posedge clk_in);
		wr_reg(12'h000, 32'hA5 ^ 32'hFF, FWD_RESP_OKAY);
		wr_reg(12'h000, 32'hA5, FWD_RESP_OKAY);
		repeat (12000) @(posedge clk_in);
		chk(34'(irq_n), 34'h1);
		wait_irq(2, 5000);
		chk({33'h0, wrst}, 34'h0);
		n = 0;
		while (wrst !== 1'b1 && n < 17000)
		begin
			@(posedge clk_in);
			n++;
		end
		chk({33'h0, wrst}, 34'h1);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		chk({33'h0, wrst}, 34'h0);
		rd_chk(12'h004, 32'h2, FWD_RESP_OKAY);
		wr_reg(12'h004, 32'h0, FWD_RESP_OKAY);
		opa <= 1'b0;
		opb <= 1'b1;
		hlt <= 1'b1;
		repeat (17000) @(posedge clk_in);
		chk(34'(irq_n), 34'h0);
		hlt <= 1'b0;
		stp <= 1'b1;
		repeat (17000) @(posedge clk_in);
		chk(34'(irq_n), 34'h0);
		chk(34'(wake_n), 34'h1);
		tally_and_finish;
	end
endmodule
